// ---- clkb_consts.svh ----
// constants and contract of the clock bank control block
// Contract
// [RULE1] each bank is controlled alone; a low off input enables it in any mode (the code disables both banks in test while second off is high)
// [RULE2] off high gives high impedance with mode high, stopped-low with mode low
// [RULE3] stopped-low is reached within six cycles of that bank's output clock
// [RULE4] stopped outputs are forced low only at their own falling edge
// [RULE5] high impedance disable releases the whole bank at once
// [RULE6] mode at middle level enters factory test whatever the off inputs
// [RULE7] each feedback cycle compares phases and flags error beyond the limit
// [RULE8] while locked, four consecutive errored feedback cycles drop lock low
// [RULE9] while unlocked, 32 consecutive clean feedback cycles raise lock; errors restart
// [RULE10] watchdog drops lock when feedback stops after lock was shown
// [RULE11] watchdog time-out counts a divided reference clock, not feedback
// [RULE12] the outside keeps the reference toggling whenever lock is relied on
// [RULE13] in test mode the reference level replaces the pll clock
// [RULE14] in test mode the feedback input is forced low inside
// [RULE15] in test mode dividers run; pll and bank disables are inactive
// [RULE16] the outside holds the mode input static
// [RULE17] in test, second off high disables all; five reference edges reset state
// [RULE18] the reset state depends on divide, skew and frequency range selections
// [RULE19] outputs stay high impedance and state held until second off falls
// [RULE20] three-level straps are held static by the outside
// [RULE21] off inputs are synchronised before the stop sequence acts
// [RULE22] lock detector restarts unlocked with counters cleared after reset or test
`ifndef CLKB_CONSTS_SVH
`define CLKB_CONSTS_SVH
`define CLKB_OFS_CTRL 8'h00
`define CLKB_OFS_STAT 8'h04
`define CLKB_OFS_LCFG 8'h08
`define CLKB_CTRL_RST 32'h0000_0000
`define CLKB_LCFG_RST 32'h0000_4003
`define CLKB_F_DIV1 3:0
`define CLKB_F_DIV2 7:4
`define CLKB_F_SKW1 11:8
`define CLKB_F_SKW2 15:12
`define CLKB_F_FS 17:16
`define CLKB_F_LIM 3:0
`define CLKB_F_WTO 15:8
`define CLKB_S_LOCK 0
`define CLKB_S_TEST 1
`define CLKB_S_STOP1 2
`define CLKB_S_STOP2 3
`define CLKB_S_HIZ1 4
`define CLKB_S_HIZ2 5
`define CLKB_S_PERR 6
`define CLKB_S_HOLD 7
`define CLKB_PIN_LOW 2'h0
`define CLKB_PIN_MID 2'h1
`define CLKB_PIN_HIGH 2'h2
`define CLKB_LOSS_CNT 3'h4
`define CLKB_GAIN_CNT 6'h20
`define CLKB_TEST_EDGES 3'h5
`define CLKB_REF_DIV 4'h8
`define CLKB_AGE_MAX 8'hff
`define CLKB_STOP_MAX 7'h06
`endif

// ---- clkb_pkg.sv ----
// types and shared decoding of the clock bank control block
package clkb_pkg;
  typedef enum logic [1:0] {MODE_LOW, MODE_MID, MODE_HIGH} clkb_mode_type;
  typedef enum logic {LK_UNLOCKED, LK_LOCKED} clkb_lock_type;
  typedef enum logic [1:0] {TR_RUN, TR_COUNT, TR_HOLD} clkb_trst_type;

  function automatic logic [3:0] ratio_of(input logic [3:0] code);
    unique case (code)
      4'h0: ratio_of = 4'h1;
      4'h1: ratio_of = 4'h2;
      4'h2: ratio_of = 4'h3;
      4'h3: ratio_of = 4'h4;
      4'h4: ratio_of = 4'h5;
      4'h5: ratio_of = 4'h6;
      4'h6: ratio_of = 4'h8;
      4'h7: ratio_of = 4'ha;
      4'h8: ratio_of = 4'hc;
      default: ratio_of = 4'h1;
    endcase
  endfunction : ratio_of

  function automatic logic [3:0] preset_of(input logic [3:0] ratio,
                                            input logic [3:0] skew,
                                            input logic [1:0] fs);
    logic [4:0] sum;
    sum = 5'(skew) + 5'(fs);
    preset_of = 4'(sum % 5'(ratio));
  endfunction : preset_of
endpackage : clkb_pkg

// ---- clkb_bank.sv ----
// one output bank: divider, off sync, stop-low and high impedance control
`timescale 1ns/1ps
`default_nettype none
`include "clkb_consts.svh"
module clkb_bank (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic src_level,
  input wire logic src_rise,
  input wire logic off_in,
  input wire logic mode_high,
  input wire logic test_mode,
  input wire logic force_hiz,
  input wire logic hold,
  input wire logic [3:0] ratio,
  input wire logic [3:0] preset,
  output logic q_r,
  output logic oe_n_r,
  output logic stopped_r
);
  logic off_meta_r;
  logic off_sync_r;
  logic [3:0] cnt_r;
  logic div_nxt;
  logic stop_req;
  logic hiz_req;
  logic stopped_nxt;
  logic [6:0] wait_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      off_meta_r <= 1'b0;
      off_sync_r <= 1'b0;
    end else begin
      off_meta_r <= off_in; // RULE21
      off_sync_r <= off_meta_r;
    end
  end

  // off input disables act only outside test; in test force_hiz disables a bank even with its off input low
  assign hiz_req = force_hiz | (!test_mode & off_sync_r & mode_high); // RULE2 RULE15
  assign stop_req = !test_mode & off_sync_r & !mode_high; // RULE1 RULE2

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 4'h0;
    end else if (hold) begin
      cnt_r <= preset; // RULE18
    end else if (src_rise) begin
      cnt_r <= (cnt_r >= 4'(ratio - 4'h1)) ? 4'h0 : 4'(cnt_r + 4'h1);
    end
  end

  always_comb begin
    div_nxt = (ratio == 4'h1) ? src_level : (cnt_r < 4'((5'(ratio) + 5'h1) >> 1));
    stopped_nxt = stop_req & (stopped_r | !div_nxt); // RULE4
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_r <= 1'b0;
      stopped_r <= 1'b0;
      oe_n_r <= 1'b1;
    end else begin
      stopped_r <= stopped_nxt; // RULE3
      q_r <= stopped_nxt ? 1'b0 : div_nxt;
      oe_n_r <= hiz_req; // RULE5
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_r <= 7'h00;
    end else if (!stop_req || stopped_r) begin
      wait_r <= 7'h00;
    end else if (src_rise && wait_r != 7'h7f) begin
      wait_r <= 7'(wait_r + 7'h01);
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_sync;
    $rose(off_sync_r) |-> $past(off_in, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("off input acted on unsynchronised"); // RULE21
  property p_stop_low;
    stopped_r |-> !q_r;
  endproperty
  a_stop_low: assert property (p_stop_low) else $error("stopped output not low"); // RULE4
  property p_stop_bound;
    stop_req |-> wait_r <= 7'(ratio * `CLKB_STOP_MAX);
  endproperty
  a_stop_bound: assert property (p_stop_bound) else $error("stop took too long"); // RULE3
  property p_hiz;
    hiz_req |=> oe_n_r;
  endproperty
  a_hiz: assert property (p_hiz) else $error("bank not released"); // RULE5
endmodule : clkb_bank
`default_nettype wire

// ---- clkb_top.sv ----
// clock bank control top: apb registers, lock detector, test reset, banks
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "clkb_consts.svh"
module clkb_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  input wire logic ref_in,
  input wire logic pll_clk_in,
  input wire logic feedback_input,
  input wire logic [1:0] mode_level,
  input wire logic [1:0] bank_off_inputs,
  output logic [3:0] first_bank_outputs,
  output logic first_bank_oe_n,
  output logic [5:0] second_bank_outputs,
  output logic second_bank_oe_n,
  output logic lock_out
);
  logic [31:0] ctrl_r;
  logic [31:0] lcfg_r;
  logic [31:0] stat;
  logic [31:0] rd_mux;
  logic acc;
  logic wr_en;
  logic hit;
  clkb_pkg::clkb_mode_type mode;
  logic test_mode;
  logic mode_high;
  logic second_off;
  logic src_level;
  logic src_prev_r;
  logic src_rise;
  logic ref_prev_r;
  logic ref_rise;
  logic fb_eff;
  logic fb_prev_r;
  logic fb_rise;
  logic [7:0] ref_age_r;
  logic perr_now;
  logic perr_r;
  clkb_pkg::clkb_lock_type lock_st_r;
  logic [2:0] err_cnt_r;
  logic [5:0] ok_cnt_r;
  logic [3:0] ref_div_r;
  logic wd_tick;
  logic [7:0] wd_cnt_r;
  logic wd_exp;
  clkb_pkg::clkb_trst_type trs_r;
  logic [2:0] edge_cnt_r;
  logic all_hiz;
  logic fsm_hold;
  logic [3:0] ratio1;
  logic [3:0] ratio2;
  logic [3:0] preset1;
  logic [3:0] preset2;
  logic q1;
  logic q2;
  logic oe1_n;
  logic oe2_n;
  logic stop1;
  logic stop2;

  // apb slave, one wait state
  assign acc = psel & penable & !pready;
  assign wr_en = psel & penable & pready & pwrite;
  assign hit = (paddr == `CLKB_OFS_CTRL) || (paddr == `CLKB_OFS_STAT) ||
               (paddr == `CLKB_OFS_LCFG);

  always_comb begin
    stat = 32'h0000_0000;
    stat[`CLKB_S_LOCK] = lock_out;
    stat[`CLKB_S_TEST] = test_mode;
    stat[`CLKB_S_STOP1] = stop1;
    stat[`CLKB_S_STOP2] = stop2;
    stat[`CLKB_S_HIZ1] = oe1_n;
    stat[`CLKB_S_HIZ2] = oe2_n;
    stat[`CLKB_S_PERR] = perr_r;
    stat[`CLKB_S_HOLD] = fsm_hold;
    unique case (paddr)
      `CLKB_OFS_CTRL: rd_mux = ctrl_r;
      `CLKB_OFS_STAT: rd_mux = stat;
      `CLKB_OFS_LCFG: rd_mux = lcfg_r;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= acc;
      pslverr <= acc & !hit;
      prdata <= (acc && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `CLKB_CTRL_RST;
      lcfg_r <= `CLKB_LCFG_RST;
    end else if (wr_en) begin
      if (paddr == `CLKB_OFS_CTRL) begin
        ctrl_r <= pwdata;
      end
      if (paddr == `CLKB_OFS_LCFG) begin
        lcfg_r <= pwdata;
      end
    end
  end

  // mode strap decode; an undefined code counts as middle
  always_comb begin
    unique case (mode_level)
      `CLKB_PIN_LOW: mode = clkb_pkg::MODE_LOW;
      `CLKB_PIN_HIGH: mode = clkb_pkg::MODE_HIGH;
      default: mode = clkb_pkg::MODE_MID;
    endcase
  end
  assign test_mode = (mode == clkb_pkg::MODE_MID); // RULE6 RULE16 RULE20
  assign mode_high = (mode == clkb_pkg::MODE_HIGH);
  assign second_off = bank_off_inputs[1];

  // pll bypass and feedback tie-off in test
  assign src_level = test_mode ? ref_in : pll_clk_in; // RULE13
  assign fb_eff = test_mode ? 1'b0 : feedback_input; // RULE14
  assign src_rise = src_level & !src_prev_r;
  assign ref_rise = ref_in & !ref_prev_r;
  assign fb_rise = fb_eff & !fb_prev_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_prev_r <= 1'b0;
      ref_prev_r <= 1'b0;
      fb_prev_r <= 1'b0;
    end else begin
      src_prev_r <= src_level;
      ref_prev_r <= ref_in;
      fb_prev_r <= fb_eff;
    end
  end

  // phase comparison: age of last reference edge at each feedback edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_age_r <= `CLKB_AGE_MAX;
    end else if (ref_rise) begin
      ref_age_r <= 8'h00;
    end else if (ref_age_r != `CLKB_AGE_MAX) begin
      ref_age_r <= 8'(ref_age_r + 8'h01);
    end
  end
  assign perr_now = ref_age_r > 8'(lcfg_r[`CLKB_F_LIM]); // RULE7

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      perr_r <= 1'b0;
    end else if (fb_rise) begin
      perr_r <= perr_now; // RULE7
    end
  end

  // watchdog timebase from the divided reference
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_div_r <= 4'h0;
    end else if (ref_rise) begin
      ref_div_r <= (ref_div_r == 4'(`CLKB_REF_DIV - 4'h1)) ? 4'h0 : 4'(ref_div_r + 4'h1);
    end
  end
  assign wd_tick = ref_rise && (ref_div_r == 4'(`CLKB_REF_DIV - 4'h1)); // RULE11 RULE12

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_cnt_r <= 8'h00;
    end else if (fb_rise || lock_st_r == clkb_pkg::LK_UNLOCKED) begin
      wd_cnt_r <= 8'h00;
    end else if (wd_tick && wd_cnt_r != 8'hff) begin
      wd_cnt_r <= 8'(wd_cnt_r + 8'h01); // RULE11
    end
  end
  assign wd_exp = (wd_cnt_r >= lcfg_r[`CLKB_F_WTO]); // RULE10

  // lock state machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_st_r <= clkb_pkg::LK_UNLOCKED;
      lock_out <= 1'b0;
      err_cnt_r <= 3'h0;
      ok_cnt_r <= 6'h00;
    end else if (test_mode) begin
      lock_st_r <= clkb_pkg::LK_UNLOCKED; // RULE15 RULE22
      lock_out <= 1'b0;
      err_cnt_r <= 3'h0;
      ok_cnt_r <= 6'h00;
    end else begin
      unique case (lock_st_r)
        clkb_pkg::LK_UNLOCKED: begin
          if (fb_rise) begin
            if (perr_now) begin
              ok_cnt_r <= 6'h00; // RULE9
            end else if (ok_cnt_r == 6'(`CLKB_GAIN_CNT - 6'h01)) begin
              lock_st_r <= clkb_pkg::LK_LOCKED; // RULE9
              lock_out <= 1'b1;
              ok_cnt_r <= 6'h00;
              err_cnt_r <= 3'h0;
            end else begin
              ok_cnt_r <= 6'(ok_cnt_r + 6'h01);
            end
          end
        end
        clkb_pkg::LK_LOCKED: begin
          if (wd_exp) begin
            lock_st_r <= clkb_pkg::LK_UNLOCKED; // RULE10
            lock_out <= 1'b0;
            err_cnt_r <= 3'h0;
          end else if (fb_rise) begin
            if (!perr_now) begin
              err_cnt_r <= 3'h0;
            end else if (err_cnt_r == 3'(`CLKB_LOSS_CNT - 3'h1)) begin
              lock_st_r <= clkb_pkg::LK_UNLOCKED; // RULE8
              lock_out <= 1'b0;
              err_cnt_r <= 3'h0;
            end else begin
              err_cnt_r <= 3'(err_cnt_r + 3'h1);
            end
          end
        end
      endcase
    end
  end

  // test-mode deterministic reset sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trs_r <= clkb_pkg::TR_RUN;
      edge_cnt_r <= 3'h0;
    end else if (!test_mode) begin
      trs_r <= clkb_pkg::TR_RUN;
      edge_cnt_r <= 3'h0;
    end else begin
      unique case (trs_r)
        clkb_pkg::TR_RUN: begin
          edge_cnt_r <= 3'h0;
          if (second_off) begin
            trs_r <= clkb_pkg::TR_COUNT; // RULE17
          end
        end
        clkb_pkg::TR_COUNT: begin
          if (!second_off) begin
            trs_r <= clkb_pkg::TR_RUN;
          end else if (ref_rise) begin
            if (edge_cnt_r == 3'(`CLKB_TEST_EDGES - 3'h1)) begin
              trs_r <= clkb_pkg::TR_HOLD; // RULE17
            end else begin
              edge_cnt_r <= 3'(edge_cnt_r + 3'h1);
            end
          end
        end
        clkb_pkg::TR_HOLD: begin
          if (!second_off) begin
            trs_r <= clkb_pkg::TR_RUN; // RULE19
          end
        end
        default: trs_r <= clkb_pkg::TR_RUN;
      endcase
    end
  end
  assign all_hiz = test_mode && (trs_r != clkb_pkg::TR_RUN); // RULE17 RULE19
  assign fsm_hold = test_mode && (trs_r == clkb_pkg::TR_HOLD); // RULE19

  // divide selections and the preset they imply
  assign ratio1 = clkb_pkg::ratio_of(ctrl_r[`CLKB_F_DIV1]);
  assign ratio2 = clkb_pkg::ratio_of(ctrl_r[`CLKB_F_DIV2]);
  assign preset1 = clkb_pkg::preset_of(ratio1, ctrl_r[`CLKB_F_SKW1], ctrl_r[`CLKB_F_FS]); // RULE18
  assign preset2 = clkb_pkg::preset_of(ratio2, ctrl_r[`CLKB_F_SKW2], ctrl_r[`CLKB_F_FS]); // RULE18

  clkb_bank u_bank1 (
    .clk(pclk),
    .rst_n(presetn),
    .src_level(src_level),
    .src_rise(src_rise),
    .off_in(bank_off_inputs[0]),
    .mode_high(mode_high),
    .test_mode(test_mode),
    .force_hiz(all_hiz),
    .hold(fsm_hold),
    .ratio(ratio1),
    .preset(preset1),
    .q_r(q1),
    .oe_n_r(oe1_n),
    .stopped_r(stop1)
  );

  clkb_bank u_bank2 (
    .clk(pclk),
    .rst_n(presetn),
    .src_level(src_level),
    .src_rise(src_rise),
    .off_in(bank_off_inputs[1]),
    .mode_high(mode_high),
    .test_mode(test_mode),
    .force_hiz(all_hiz),
    .hold(fsm_hold),
    .ratio(ratio2),
    .preset(preset2),
    .q_r(q2),
    .oe_n_r(oe2_n),
    .stopped_r(stop2)
  );

  // each bank pin group follows its own bank flops
  assign first_bank_outputs = {4{q1}}; // RULE1
  assign first_bank_oe_n = oe1_n;
  assign second_bank_outputs = {6{q2}}; // RULE1
  assign second_bank_oe_n = oe2_n;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_fifth_edge;
    test_mode && trs_r == clkb_pkg::TR_COUNT && second_off && ref_rise &&
    edge_cnt_r == 3'(`CLKB_TEST_EDGES - 3'h1);
  endsequence
  sequence s_all_hiz;
    trs_r == clkb_pkg::TR_HOLD ##1 first_bank_oe_n && second_bank_oe_n;
  endsequence

  property p_perr;
    fb_rise |=> perr_r == ($past(ref_age_r) > 8'($past(lcfg_r[`CLKB_F_LIM])));
  endproperty
  a_perr: assert property (p_perr) else $error("phase error verdict wrong"); // RULE7
  property p_loss;
    lock_out && !test_mode && fb_rise && perr_now &&
    err_cnt_r == 3'(`CLKB_LOSS_CNT - 3'h1) |=> !lock_out;
  endproperty
  a_loss: assert property (p_loss) else $error("lock kept after four errors"); // RULE8
  property p_gain;
    $rose(lock_out) |-> $past(ok_cnt_r) == 6'(`CLKB_GAIN_CNT - 6'h01) &&
    $past(fb_rise) && !$past(perr_now);
  endproperty
  a_gain: assert property (p_gain) else $error("lock raised early"); // RULE9
  property p_restart;
    !lock_out && !test_mode && fb_rise && perr_now |=> ok_cnt_r == 6'h00 && !lock_out;
  endproperty
  a_restart: assert property (p_restart) else $error("error did not restart count"); // RULE9
  property p_wdog;
    lock_out && !test_mode && wd_exp |=> !lock_out;
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog did not drop lock"); // RULE10
  property p_wd_ref;
    wd_cnt_r > $past(wd_cnt_r) |-> $past(wd_tick);
  endproperty
  a_wd_ref: assert property (p_wd_ref) else $error("watchdog counted without tick"); // RULE11
  property p_fb_low;
    test_mode[*2] |-> !fb_rise && !lock_out;
  endproperty
  a_fb_low: assert property (p_fb_low) else $error("feedback active in test"); // RULE14
  property p_test_seq;
    s_fifth_edge |=> s_all_hiz;
  endproperty
  a_test_seq: assert property (p_test_seq) else $error("test reset sequence wrong"); // RULE17
  property p_hold;
    fsm_hold && second_off |=> fsm_hold ##1 first_bank_oe_n;
  endproperty
  a_hold: assert property (p_hold) else $error("hold released early"); // RULE19
  property p_start;
    $fell(test_mode) |-> !lock_out && ok_cnt_r == 6'h00 && err_cnt_r == 3'h0;
  endproperty
  a_start: assert property (p_start) else $error("lock detector not restarted"); // RULE22
endmodule : clkb_top
`default_nettype wire

// ---- clkb_far_model.sv ----
// far side model: reference, pll and feedback clock sources
`timescale 1ns/1ps
`default_nettype none
module clkb_far_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] fb_lag,
  input wire logic fb_run,
  output logic ref_in,
  output logic pll_clk_in,
  output logic feedback_input
);
  logic [1:0] div_r;
  logic [15:0] hist_r;
  // reference toggles every four cycles, period eight
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 2'h0;
      ref_in <= 1'b0;
      hist_r <= 16'h0000;
    end else begin
      div_r <= 2'(div_r + 2'h1);
      if (div_r == 2'h3) ref_in <= ~ref_in;
      hist_r <= {hist_r[14:0], ref_in};
    end
  end
  assign pll_clk_in = ref_in;
  // feedback is the delayed reference; stopped feedback rests low
  assign feedback_input = fb_run & hist_r[fb_lag];
endmodule : clkb_far_model
`default_nettype wire

// ---- tb_top.sv ----
// testbench: apb access, lock detector, bank disables and test mode
`timescale 1ns/1ps
`default_nettype none
`include "clkb_consts.svh"
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, prev;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic ref_in, pll_clk_in, feedback_input, lock_out, fb_run;
  logic fb_d = 1'b0;
  logic [1:0] mode_level, bank_off_inputs;
  logic [3:0] first_bank_outputs, fb_lag;
  logic [5:0] second_bank_outputs;
  logic first_bank_oe_n, second_bank_oe_n;
  int num_errors, checked, n, base, t;
  int fb_edges = 0;
  int hi_len = 0;
  clkb_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .ref_in(ref_in), .pll_clk_in(pll_clk_in),
    .feedback_input(feedback_input), .mode_level(mode_level),
    .bank_off_inputs(bank_off_inputs), .first_bank_outputs(first_bank_outputs),
    .first_bank_oe_n(first_bank_oe_n), .second_bank_outputs(second_bank_outputs),
    .second_bank_oe_n(second_bank_oe_n), .lock_out(lock_out));
  clkb_far_model i_far (.pclk(pclk), .presetn(presetn), .fb_lag(fb_lag), .fb_run(fb_run),
    .ref_in(ref_in), .pll_clk_in(pll_clk_in), .feedback_input(feedback_input));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rq, output logic re);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, q, e);
    chk("write error", 32'h0, {31'h0, e});
  endtask : wr
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] exp);
    apb(1'b0, a, 32'h0, q, e);
    chk(what, exp, q & m);
  endtask : rd_chk
  task automatic wait_lock(input logic v, input int lim);
    n = 0;
    while (lock_out !== v && n < lim) begin
      n++;
      @(posedge pclk);
    end
  endtask : wait_lock
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  // feedback edge count and stopped bank pulse width
  always @(posedge pclk) begin
    fb_d <= feedback_input;
    if (feedback_input && !fb_d) fb_edges <= fb_edges + 1;
    if (second_bank_outputs[0]) hi_len <= hi_len + 1;
    else begin
      if (hi_len != 0 && mode_level == 2'h0) chk("pulse width", 32'h1, {31'h0, hi_len >= 4});
      hi_len <= 0;
    end
  end
  initial begin
    #200000;
    num_errors++;
    tally_and_finish();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    mode_level = 2'h2;
    bank_off_inputs = 2'h0;
    fb_lag = 4'h0;
    fb_run = 1'b1;
    num_errors = 0;
    checked = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("lock after reset", 32'h0, {31'h0, lock_out});
    rd_chk("ctrl reset", `CLKB_OFS_CTRL, 32'hffffffff, `CLKB_CTRL_RST);
    rd_chk("lcfg reset", `CLKB_OFS_LCFG, 32'hffffffff, `CLKB_LCFG_RST);
    wr(`CLKB_OFS_CTRL, 32'h0003_f5a8);
    rd_chk("ctrl readback", `CLKB_OFS_CTRL, 32'h0003_ffff, 32'h0003_f5a8);
    wr(`CLKB_OFS_CTRL, 32'h0);
    apb(1'b0, 8'h0c, 32'h0, q, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
    $display("test registers done");
    wait_lock(1'b1, 600);
    chk("edges to lock", 32'h20, fb_edges);
    base = fb_edges;
    fb_lag <= 4'h6;
    wait_lock(1'b0, 200);
    chk("edges to unlock", 32'h1, {31'h0, (fb_edges - base) inside {[4:5]}});
    rd_chk("phase error flag", `CLKB_OFS_STAT, 32'h41, 32'h40);
    fb_lag <= 4'h0;
    wait_lock(1'b1, 600);
    chk("relock", 32'h1, {31'h0, lock_out});
    wr(`CLKB_OFS_LCFG, 32'h0000_0203);
    fb_run <= 1'b0;
    wait_lock(1'b0, 400);
    // second tick of 64 cycles after the last feedback edge, up to 8 cycles before the stop
    chk("watchdog span", 32'h1, {31'h0, n inside {[56:130]}});
    wr(`CLKB_OFS_LCFG, `CLKB_LCFG_RST);
    fb_run <= 1'b1;
    $display("test lock detector done");
    bank_off_inputs <= 2'h1;
    repeat (4) @(posedge pclk);
    chk("bank1 hiz", 32'h1, {31'h0, first_bank_oe_n});
    chk("bank2 on", 32'h0, {31'h0, second_bank_oe_n});
    mode_level <= 2'h0;
    bank_off_inputs <= 2'h2;
    repeat (52) @(posedge pclk);
    rd_chk("bank2 stopped", `CLKB_OFS_STAT, 32'h3c, 32'h08);
    repeat (16) begin
      @(posedge pclk);
      chk("bank2 held low", 32'h0, {25'h0, second_bank_oe_n, second_bank_outputs});
      chk("bank1 on", 32'h0, {31'h0, first_bank_oe_n});
    end
    bank_off_inputs <= 2'h0;
    mode_level <= 2'h2;
    $display("test bank disables done");
    repeat (4) @(posedge pclk);
    mode_level <= 2'h1;
    bank_off_inputs <= 2'h1;
    repeat (8) @(posedge pclk);
    rd_chk("test flag", `CLKB_OFS_STAT, 32'h03, 32'h02);
    chk("bank1 kept on", 32'h0, {31'h0, first_bank_oe_n});
    t = 0;
    prev = first_bank_outputs[0];
    repeat (32) begin
      @(posedge pclk);
      if (first_bank_outputs[0] !== prev) t++;
      prev = first_bank_outputs[0];
    end
    chk("bank1 follows ref", 32'h1, {31'h0, t >= 6});
    repeat (300) @(posedge pclk);
    chk("no lock in test", 32'h0, {31'h0, lock_out});
    bank_off_inputs <= 2'h3;
    repeat (4) @(posedge pclk);
    chk("test all hiz", 32'h3, {30'h0, first_bank_oe_n, second_bank_oe_n});
    repeat (60) @(posedge pclk);
    rd_chk("state held", `CLKB_OFS_STAT, 32'h80, 32'h80);
    chk("still hiz", 32'h3, {30'h0, first_bank_oe_n, second_bank_oe_n});
    bank_off_inputs <= 2'h0;
    repeat (6) @(posedge pclk);
    rd_chk("hold released", `CLKB_OFS_STAT, 32'h82, 32'h02);
    chk("outputs back", 32'h0, {30'h0, first_bank_oe_n, second_bank_oe_n});
    mode_level <= 2'h2;
    @(posedge pclk);
    chk("unlocked on exit", 32'h0, {31'h0, lock_out});
    wait_lock(1'b1, 600);
    chk("lock after test", 32'h1, {31'h0, lock_out});
    $display("test factory mode done");
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
